//--- rtl/usart_pkg.sv
package usart_pkg;
    // ==========================================================
    // register byte offsets on the bus
    localparam logic [7:0] OFS_RX_CTRL = 8'h00;
    localparam logic [7:0] OFS_RX_DATA = 8'h04;
    localparam logic [7:0] OFS_TX_CTRL = 8'h08;
    localparam logic [7:0] OFS_TX_DATA = 8'h0C;
    localparam logic [7:0] OFS_BAUD = 8'h10;
    localparam logic [7:0] OFS_FLAGS = 8'h14;
    localparam logic [7:0] OFS_ENABLE = 8'h18;
    localparam logic [7:0] OFS_PRIORITY = 8'h1C;
    localparam logic [7:0] OFS_IRQ_CTRL = 8'h20;
    // ==========================================================
    // receive status/control fields
    localparam int RX_PORT_EN = 7;
    localparam int RX_NINTH_EN = 6;
    localparam int RX_SINGLE = 5;
    localparam int RX_CONT = 4;
    localparam int RX_ADDR_DET = 3;
    localparam int RX_FRAME_ERR = 2;
    localparam int RX_OVERRUN = 1;
    localparam int RX_NINTH_VAL = 0;
    // ==========================================================
    // transmit status/control fields
    localparam int TX_CLK_SRC = 7;
    localparam int TX_NINTH_EN = 6;
    localparam int TX_EN = 5;
    localparam int TX_SYNC = 4;
    localparam int TX_HIGH_SPEED = 2;
    localparam int TX_SHIFT_EMPTY = 1;
    localparam int TX_NINTH_VAL = 0;
    // ==========================================================
    // peripheral flag, enable and priority fields
    localparam int IRQ_RX_BIT = 5;
    localparam int IRQ_TX_BIT = 4;
    localparam int IRQ_GLOBAL = 7;
    localparam int IRQ_PERIPH = 6;
    // ==========================================================
    // reset values
    localparam logic [7:0] RST_PRIORITY = 8'h7F;
    localparam logic [7:0] RST_TX_CTRL = 8'h02;
    // ==========================================================
    // timing
    localparam logic [6:0] OVERSAMPLE_HIGH = 7'h10;
    localparam logic [6:0] OVERSAMPLE_LOW = 7'h40;
    localparam logic [3:0] BITS_SHORT = 4'h8;
    localparam logic [3:0] BITS_LONG = 4'h9;
    localparam logic [1:0] FLAG_CLEAR_DELAY = 2'h2;
    // ==========================================================
    // bus encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_e;
endpackage

//--- rtl/usart_addr_detect_sync_master_tx.sv
// Chosen here: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ns
// Behaviour
// - receive interrupt priority chosen by the receive priority bit
// - receive ninth-bit enable makes receiver take 9-bit words
// - address detect enable, with ninth-bit enable set, filters which words reach the receive buffer
// - reception starts only while continuous receive enable is set
// - receive done flag set per word; interrupt needs its enable and global enable
// - receive control reports framing, overrun and holds received ninth bit
// - clearing continuous receive enable clears pending receive errors
// - without address detect every word is buffered and flagged unless the done flag is still set (then overrun)
// - in clocked master mode transmit and receive exclude each other
// - clocked-mode select, transmit control bit 4, picks synchronous operation
// - port enable, receive control bit 7, turns pins into clock and data
// - clock source select, transmit control bit 7, makes device drive clock
// - shift register reloads only after last bit and only if buffer full
// - buffer-to-shift transfer takes one cycle and sets buffer empty flag bit 4
// - buffer empty flag ignores enable, not software clearable, cleared by write
// - read-only shift-empty bit 1 set while shift register empty, no interrupt
// - shift register is not reachable by software
// - ninth transmit bit taken from transmit ninth-bit value when enabled
// - with transmit enable a buffer write starts a clocked master transmission
// - buffer empty flag clears from the second cycle after the write
// - sampling clock is 16 or 64 times the bit rate per high-speed select
// - words shift least significant bit first both ways
module usart_addr_detect_sync_master_tx (
    input wire logic clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic serial_data_line_in,
    output logic serial_data_line_out,
    output logic serial_data_line_oe_n,
    output logic shift_clock_line_out,
    output logic shift_clock_line_oe_n,
    output logic irq_high,
    output logic irq_low
);
    import usart_pkg::*;

    // ==========================================================
    // state
    typedef struct packed {
        logic [7:0] wr_addr;
        logic wr_pend;
        logic [31:0] rdata;
        logic port_enable;
        logic receive_ninth_bit_enable;
        logic single_receive_enable;
        logic continuous_receive_enable;
        logic address_detect_enable;
        logic framing_error_flag;
        logic overrun_error_flag;
        logic receive_ninth_bit_value;
        logic clock_source_select;
        logic transmit_ninth_bit_enable;
        logic transmit_enable;
        logic sync_mode;
        logic high_speed_baud_select;
        logic transmit_ninth_bit_value;
        logic [7:0] baud_divisor;
        logic [7:0] irq_enable;
        logic [7:0] irq_priority;
        logic global_irq_enable;
        logic peripheral_irq_enable;
        logic [7:0] baud_count;
        logic baud_tick;
        logic line_meta;
        logic line_sync;
        rx_state_e rx_state;
        logic [6:0] os_count;
        logic [3:0] rx_bits;
        logic [8:0] rx_shift;
        logic [7:0] receive_data_buffer;
        logic receive_done_flag;
        logic [7:0] transmit_data_buffer;
        logic tx_buf_full;
        logic transmit_buffer_empty_flag;
        logic [1:0] flag_clear_wait;
        logic [8:0] transmit_shift_register;
        logic [3:0] tx_bits;
        logic tx_busy;
        logic sck;
        logic data_out;
        logic clk_oe_n;
        logic data_oe_n;
        logic irq_high;
        logic irq_low;
    } state_s;

    state_s st;
    state_s next_st;

    // ==========================================================
    // register read view
    function automatic logic [7:0] read_reg(input state_s s, input logic [7:0] a);
        logic [7:0] v;
        v = 8'h00;
        if (a == OFS_RX_CTRL) begin
            v[RX_PORT_EN] = s.port_enable;
            v[RX_NINTH_EN] = s.receive_ninth_bit_enable;
            v[RX_SINGLE] = s.single_receive_enable;
            v[RX_CONT] = s.continuous_receive_enable;
            v[RX_ADDR_DET] = s.address_detect_enable;
            v[RX_FRAME_ERR] = s.framing_error_flag;
            v[RX_OVERRUN] = s.overrun_error_flag;
            v[RX_NINTH_VAL] = s.receive_ninth_bit_value;
        end else if (a == OFS_RX_DATA) begin
            v = s.receive_data_buffer;
        end else if (a == OFS_TX_CTRL) begin
            v[TX_CLK_SRC] = s.clock_source_select;
            v[TX_NINTH_EN] = s.transmit_ninth_bit_enable;
            v[TX_EN] = s.transmit_enable;
            v[TX_SYNC] = s.sync_mode;
            v[TX_HIGH_SPEED] = s.high_speed_baud_select;
            v[TX_SHIFT_EMPTY] = ~s.tx_busy;
            v[TX_NINTH_VAL] = s.transmit_ninth_bit_value;
        end else if (a == OFS_TX_DATA) begin
            v = s.transmit_data_buffer;
        end else if (a == OFS_BAUD) begin
            v = s.baud_divisor;
        end else if (a == OFS_FLAGS) begin
            v[IRQ_RX_BIT] = s.receive_done_flag;
            v[IRQ_TX_BIT] = s.transmit_buffer_empty_flag;
        end else if (a == OFS_ENABLE) begin
            v = s.irq_enable;
        end else if (a == OFS_PRIORITY) begin
            v = s.irq_priority;
        end else if (a == OFS_IRQ_CTRL) begin
            v[IRQ_GLOBAL] = s.global_irq_enable;
            v[IRQ_PERIPH] = s.peripheral_irq_enable;
        end
        return v;
    endfunction

    logic addr_phase;
    logic rx_allowed;
    logic tx_allowed;
    logic [6:0] os_per_bit;
    logic [3:0] rx_len;
    logic [7:0] wd;
    logic rx_req;
    logic tx_req;

    always_comb begin
        next_st = st;
        wd = hwdata[7:0];
        addr_phase = hsel && hready && (htrans == HTRANS_NONSEQ);
        os_per_bit = st.high_speed_baud_select ? OVERSAMPLE_HIGH : OVERSAMPLE_LOW;
        rx_len = st.receive_ninth_bit_enable ? BITS_LONG : BITS_SHORT;
        // receiver only in asynchronous mode, not while an overrun is pending
        rx_allowed = st.port_enable && !st.sync_mode && st.continuous_receive_enable
            && !st.overrun_error_flag;
        // master transmit stays off while any receive enable is set
        tx_allowed = st.port_enable && st.sync_mode && st.clock_source_select
            && st.transmit_enable && !st.single_receive_enable
            && !st.continuous_receive_enable;
        // ======================================================
        // baud generator
        next_st.baud_tick = 1'b0;
        if (st.baud_count == 8'h00) begin
            next_st.baud_count = st.baud_divisor;
            next_st.baud_tick = 1'b1;
        end else begin
            next_st.baud_count = st.baud_count - 8'h01;
        end
        // ======================================================
        // line synchroniser
        next_st.line_meta = serial_data_line_in;
        next_st.line_sync = st.line_meta;
        // ======================================================
        // asynchronous receiver
        if (!rx_allowed) begin
            next_st.rx_state = RX_IDLE;
        end else if (st.baud_tick) begin
            next_st.os_count = st.os_count - 7'h01;
            case (st.rx_state)
                RX_IDLE: begin
                    if (!st.line_sync) begin
                        next_st.rx_state = RX_START;
                        next_st.os_count = {1'b0, os_per_bit[6:1]} - 7'h01;
                    end
                end
                RX_START: begin
                    if (st.os_count == 7'h00) begin
                        if (st.line_sync) begin
                            next_st.rx_state = RX_IDLE;
                        end else begin
                            next_st.rx_state = RX_DATA;
                            next_st.os_count = os_per_bit - 7'h01;
                            next_st.rx_bits = rx_len;
                            next_st.rx_shift = 9'h000;
                        end
                    end
                end
                RX_DATA: begin
                    if (st.os_count == 7'h00) begin
                        next_st.os_count = os_per_bit - 7'h01;
                        next_st.rx_shift = {st.line_sync, st.rx_shift[8:1]};
                        next_st.rx_bits = st.rx_bits - 4'h1;
                        if (st.rx_bits == 4'h1) begin
                            next_st.rx_state = RX_STOP;
                        end
                    end
                end
                RX_STOP: begin
                    if (st.os_count == 7'h00) begin
                        next_st.rx_state = RX_IDLE;
                        if (st.receive_ninth_bit_enable && st.address_detect_enable
                            && !st.rx_shift[8]) begin
                            next_st.rx_state = RX_IDLE;
                        end else if (st.receive_done_flag) begin
                            next_st.overrun_error_flag = 1'b1;
                        end else begin
                            // short words land right-aligned
                            if (st.receive_ninth_bit_enable) begin
                                next_st.receive_data_buffer = st.rx_shift[7:0];
                                next_st.receive_ninth_bit_value = st.rx_shift[8];
                            end else begin
                                next_st.receive_data_buffer = st.rx_shift[8:1];
                                next_st.receive_ninth_bit_value = 1'b0;
                            end
                            next_st.framing_error_flag = !st.line_sync;
                            next_st.receive_done_flag = 1'b1;
                        end
                    end
                end
                default: next_st.rx_state = RX_IDLE;
            endcase
        end
        // ======================================================
        // synchronous master transmitter
        if (st.flag_clear_wait != 2'h0) begin
            next_st.flag_clear_wait = st.flag_clear_wait - 2'h1;
            if (st.flag_clear_wait == 2'h1 && st.tx_buf_full) begin
                next_st.transmit_buffer_empty_flag = 1'b0;
            end
        end
        if (!tx_allowed) begin
            next_st.tx_busy = 1'b0;
            next_st.sck = 1'b0;
        end else if (st.tx_busy) begin
            if (st.baud_tick) begin
                next_st.sck = ~st.sck;
                if (st.sck) begin
                    next_st.transmit_shift_register = {1'b0, st.transmit_shift_register[8:1]};
                    next_st.data_out = st.transmit_shift_register[1];
                    next_st.tx_bits = st.tx_bits - 4'h1;
                    if (st.tx_bits == 4'h1) begin
                        next_st.tx_busy = 1'b0;
                    end
                end
            end
        end else if (st.tx_buf_full) begin
            next_st.transmit_shift_register = {st.transmit_ninth_bit_value,
                st.transmit_data_buffer};
            next_st.data_out = st.transmit_data_buffer[0];
            next_st.tx_bits = st.transmit_ninth_bit_enable ? BITS_LONG : BITS_SHORT;
            next_st.tx_busy = 1'b1;
            next_st.tx_buf_full = 1'b0;
            next_st.transmit_buffer_empty_flag = 1'b1;
            next_st.flag_clear_wait = 2'h0;
        end
        // ======================================================
        // bus slave, address phase reads
        next_st.wr_pend = addr_phase && hwrite;
        next_st.wr_addr = haddr[7:0];
        if (addr_phase && !hwrite) begin
            if (haddr[31:8] == 24'h000000) begin
                next_st.rdata = {24'h000000, read_reg(st, haddr[7:0])};
            end else begin
                next_st.rdata = 32'h00000000;
            end
            if (haddr[31:8] == 24'h000000 && haddr[7:0] == OFS_RX_DATA) begin
                // a word landing in this same cycle keeps its flag
                next_st.receive_done_flag = next_st.receive_done_flag
                    && !st.receive_done_flag;
            end
        end
        // ======================================================
        // bus slave, data phase writes
        if (st.wr_pend) begin
            if (st.wr_addr == OFS_RX_CTRL) begin
                next_st.port_enable = wd[RX_PORT_EN];
                next_st.receive_ninth_bit_enable = wd[RX_NINTH_EN];
                next_st.single_receive_enable = wd[RX_SINGLE];
                next_st.continuous_receive_enable = wd[RX_CONT];
                next_st.address_detect_enable = wd[RX_ADDR_DET];
                if (!wd[RX_CONT]) begin
                    next_st.overrun_error_flag = next_st.overrun_error_flag
                        && !st.overrun_error_flag;
                    next_st.framing_error_flag = 1'b0;
                end
            end else if (st.wr_addr == OFS_TX_CTRL) begin
                next_st.clock_source_select = wd[TX_CLK_SRC];
                next_st.transmit_ninth_bit_enable = wd[TX_NINTH_EN];
                next_st.transmit_enable = wd[TX_EN];
                next_st.sync_mode = wd[TX_SYNC];
                next_st.high_speed_baud_select = wd[TX_HIGH_SPEED];
                next_st.transmit_ninth_bit_value = wd[TX_NINTH_VAL];
                if (wd[TX_EN] && !st.transmit_enable && !st.tx_buf_full) begin
                    next_st.transmit_buffer_empty_flag = 1'b1;
                end
            end else if (st.wr_addr == OFS_TX_DATA) begin
                next_st.transmit_data_buffer = wd;
                next_st.tx_buf_full = 1'b1;
                next_st.flag_clear_wait = FLAG_CLEAR_DELAY;
            end else if (st.wr_addr == OFS_BAUD) begin
                next_st.baud_divisor = wd;
            end else if (st.wr_addr == OFS_ENABLE) begin
                next_st.irq_enable = wd;
            end else if (st.wr_addr == OFS_PRIORITY) begin
                next_st.irq_priority = wd;
            end else if (st.wr_addr == OFS_IRQ_CTRL) begin
                next_st.global_irq_enable = wd[IRQ_GLOBAL];
                next_st.peripheral_irq_enable = wd[IRQ_PERIPH];
            end
        end
        // ======================================================
        // pins and interrupt requests
        next_st.clk_oe_n = !(st.port_enable && st.sync_mode
            && st.clock_source_select);
        next_st.data_oe_n = !tx_allowed;
        rx_req = st.receive_done_flag && st.irq_enable[IRQ_RX_BIT];
        tx_req = st.transmit_buffer_empty_flag && st.irq_enable[IRQ_TX_BIT];
        next_st.irq_high = st.global_irq_enable
            && ((rx_req && st.irq_priority[IRQ_RX_BIT])
            || (tx_req && st.irq_priority[IRQ_TX_BIT]));
        next_st.irq_low = st.global_irq_enable && st.peripheral_irq_enable
            && ((rx_req && !st.irq_priority[IRQ_RX_BIT])
            || (tx_req && !st.irq_priority[IRQ_TX_BIT]));
    end

    // ==========================================================
    // state register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st <= '0;
            st.irq_priority <= RST_PRIORITY;
            st.line_meta <= 1'b1;
            st.line_sync <= 1'b1;
            st.clk_oe_n <= 1'b1;
            st.data_oe_n <= 1'b1;
            st.data_out <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // ==========================================================
    // outputs
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = st.rdata;
    assign serial_data_line_out = st.data_out;
    assign serial_data_line_oe_n = st.data_oe_n;
    assign shift_clock_line_out = st.sck;
    assign shift_clock_line_oe_n = st.clk_oe_n;
    assign irq_high = st.irq_high;
    assign irq_low = st.irq_low;
endmodule

//--- verif/usart_checker_asserts.sv
`timescale 1ns/1ns
module usart_checker (
    input wire logic clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic serial_data_line_out,
    input wire logic serial_data_line_oe_n,
    input wire logic shift_clock_line_out,
    input wire logic shift_clock_line_oe_n,
    input wire logic irq_high,
    input wire logic irq_low
);
    // ========
    // read request decode
    logic rd_req;
    assign rd_req = hsel && hready && (htrans == 2'h2) && !hwrite;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // ========
    // bus side
    a_unmapped_zero: assert property (rd_req && (haddr[31:8] != 24'h0 || haddr[7:0] > 8'h20)
        |=> hrdata == 32'h0) else $error("unmapped read not zero");
    a_upper_zero: assert property (rd_req |=> hrdata[31:8] == 24'h0)
        else $error("upper read bits set");
    a_txctrl_gap: assert property (rd_req && haddr == 32'h8 |=> hrdata[3] == 1'b0)
        else $error("unused control bit set");
    a_rdata_holds: assert property (!rd_req |=> $stable(hrdata))
        else $error("read data moved");
    // ========
    // link side
    a_clk_idle_low: assert property (shift_clock_line_oe_n |-> !shift_clock_line_out)
        else $error("clock not idle low");
    a_data_hold_high: assert property (!serial_data_line_oe_n && shift_clock_line_out
        && $past(shift_clock_line_out) |-> $stable(serial_data_line_out))
        else $error("data moved while clock high");
    a_rise_stable: assert property ($rose(shift_clock_line_out) |->
        $stable(serial_data_line_out) && !serial_data_line_oe_n) else $error("bad clock rise");
    a_master_clock: assert property (!serial_data_line_oe_n |-> !shift_clock_line_oe_n)
        else $error("clock not driven");
    a_irq_needs_flag: assert property (rd_req && haddr == 32'h14
        |=> hrdata[5:4] != 2'h0 || !(irq_high || irq_low)) else $error("request with no flag");
    c_sck: cover property ($rose(shift_clock_line_out));
    c_irq_high: cover property ($rose(irq_high));
    c_irq_low: cover property ($rose(irq_low));
    c_rx_read: cover property (rd_req && haddr == 32'h4);
endmodule

//--- verif/usart_peer.sv
`timescale 1ns/1ns
module usart_peer (
    input wire logic clk_line,
    input wire logic data_line,
    output logic tx_line
);
    // ========
    // clocked capture on rising shift clock
    logic [8:0] got;
    int n_got;
    initial begin
        tx_line = 1'b1;
        got = 9'h000;
        n_got = 0;
    end
    always @(posedge clk_line) begin
        got = {data_line, got[8:1]};
        n_got = n_got + 1;
    end
    // ========
    // async frame, bit time 1600 ns, off the clock edge
    task automatic send(input logic [8:0] w);
        #30;
        tx_line = 1'b0;
        #1600;
        for (int i = 0; i < 9; i++) begin
            tx_line = w[i];
            #1600;
        end
        tx_line = 1'b1;
        #1600;
    endtask
endmodule

//--- verif/tb.sv
`timescale 1ns/1ns
module tb;
    import usart_pkg::*;
    logic clk, rst, hsel, hwrite, hready, hreadyout, hresp, dout, doe_n, sck, sck_oe_n;
    logic irq_high, irq_low, rx_line, data_line, clk_line;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    int mismatches = 0;
    int n_tests = 0;
    assign hready = hreadyout;
    assign data_line = !doe_n ? dout : rx_line;
    assign clk_line = !sck_oe_n ? sck : 1'b0;
    usart_addr_detect_sync_master_tx dut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .serial_data_line_in(data_line),
        .serial_data_line_out(dout), .serial_data_line_oe_n(doe_n),
        .shift_clock_line_out(sck), .shift_clock_line_oe_n(sck_oe_n),
        .irq_high(irq_high), .irq_low(irq_low));
    usart_peer peer (.clk_line(clk_line), .data_line(data_line), .tx_line(rx_line));
    // ========
    // shared tasks
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wait_ready();
        do begin
            @(posedge clk);
        end while (hready !== 1'b1);
    endtask
    task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d,
        output logic [31:0] r);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= {24'h000000, d};
        wait_ready();
        r = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        bus(a, 1'b1, d, r);
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] exp, input string what);
        logic [31:0] r;
        bus(a, 1'b0, 8'h00, r);
        check(what, r, {24'h000000, exp});
    endtask
    task automatic frame(input logic [8:0] w);
        peer.send(w);
        repeat (6) @(posedge clk);
    endtask
    task automatic wait_bits(input int k);
        while (peer.n_got < k) begin
            @(posedge clk);
        end
    endtask
    // ========
    // scenarios
    task automatic s_regs();
        rc(OFS_RX_CTRL, 8'h00, "rx ctrl reset");
        rc(OFS_TX_CTRL, RST_TX_CTRL, "tx ctrl reset");
        rc(OFS_PRIORITY, RST_PRIORITY, "priority reset");
        rc(OFS_FLAGS, 8'h00, "flags reset");
        wr(8'h40, 8'hFF);
        rc(8'h40, 8'h00, "unmapped");
        check("unmapped resp", hresp, 32'h0);
    endtask
    task automatic s_tx();
        wr(OFS_BAUD, 8'h03);
        wr(OFS_RX_CTRL, 8'h80);
        wr(OFS_TX_CTRL, 8'hF1);
        rc(OFS_FLAGS, 8'h10, "flag on enable");
        wr(OFS_FLAGS, 8'h00);
        rc(OFS_FLAGS, 8'h10, "flag kept");
        wr(OFS_TX_DATA, 8'hA5);
        wr(OFS_TX_DATA, 8'h3C);
        repeat (3) @(posedge clk);
        rc(OFS_FLAGS, 8'h00, "buffer held");
        rc(OFS_TX_CTRL, 8'hF1, "shift busy");
        wait_bits(9);
        check("first word", peer.got, 32'h1A5);
        wait_bits(18);
        check("second word", peer.got, 32'h13C);
        repeat (10) @(posedge clk);
        rc(OFS_TX_CTRL, 8'hF3, "shift empty");
        rc(OFS_FLAGS, 8'h10, "buffer empty");
        wr(OFS_RX_CTRL, 8'h90);
        wr(OFS_TX_DATA, 8'h55);
        repeat (20) @(posedge clk);
        check("tx inhibited", doe_n, 32'h1);
    endtask
    task automatic s_rx();
        wr(OFS_TX_CTRL, 8'h04);
        wr(OFS_BAUD, 8'h00);
        wr(OFS_ENABLE, 8'h20);
        wr(OFS_IRQ_CTRL, 8'h80);
        wr(OFS_RX_CTRL, 8'hC8);
        frame(9'h0AA);
        check("no rx disabled", irq_high, 32'h0);
        wr(OFS_RX_CTRL, 8'hD8);
        frame(9'h055);
        check("data word dropped", irq_high, 32'h0);
        frame(9'h13C);
        check("irq high", {irq_high, irq_low}, 32'h2);
        rc(OFS_RX_CTRL, 8'hD9, "ninth bit");
        rc(OFS_RX_DATA, 8'h3C, "address");
        @(posedge clk);
        check("read clears", irq_high, 32'h0);
        wr(OFS_PRIORITY, 8'h00);
        wr(OFS_IRQ_CTRL, 8'hC0);
        wr(OFS_RX_CTRL, 8'hD0);
        frame(9'h066);
        check("irq low", {irq_high, irq_low}, 32'h1);
        frame(9'h077);
        rc(OFS_RX_CTRL, 8'hD2, "overrun");
        rc(OFS_RX_DATA, 8'h66, "kept word");
        wr(OFS_RX_CTRL, 8'hC0);
        rc(OFS_RX_CTRL, 8'hC0, "errors cleared");
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        rst = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        s_regs();
        s_tx();
        s_rx();
        summarize();
    end
    initial begin
        #600000;
        mismatches++;
        summarize();
    end
endmodule
bind usart_addr_detect_sync_master_tx usart_checker u_chk (.clk(clk), .rst(rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
    .serial_data_line_out(serial_data_line_out), .serial_data_line_oe_n(serial_data_line_oe_n),
    .shift_clock_line_out(shift_clock_line_out), .shift_clock_line_oe_n(shift_clock_line_oe_n),
    .irq_high(irq_high), .irq_low(irq_low));
